/* File: src/rxso_map.svh */
/*
  Constants of the receive segmented packet output: widths, register
  offsets, field positions, reset values and counts.
  Assumes it is included by its bare name from the package and the top.
*/
`ifndef RXSO_MAP_SVH
`define RXSO_MAP_SVH

// Segment shape of the user bus.
`define RXSO_SEGS        4
`define RXSO_DW          128
`define RXSO_CW          11
`define RXSO_MW          4
`define RXSO_LW          146
// Sampled link word: the segment fields with the valid bit on top.
`define RXSO_RAW_W       147
`define RXSO_CHAN_ALL    11'h7FF
`define RXSO_CHAN_BITS   4'hB
`define RXSO_MTY_NONE    4'h0

// Slot counter values.
`define RXSO_CNT_ZERO    3'h0
`define RXSO_CNT_FULL    3'h4
`define RXSO_CNT_ONE     3'h1

// Register byte offsets.
`define RXSO_OFS_CTRL    8'h00
`define RXSO_OFS_DIV     8'h04
`define RXSO_OFS_STATUS  8'h08
`define RXSO_OFS_MASK    8'h0C
`define RXSO_OFS_DROP    8'h10

// Control fields: enable bit and channel range field.
`define RXSO_CTRL_EN     0
`define RXSO_CTRL_RNG_LO 4
`define RXSO_CTRL_RNG_HI 7
`define RXSO_CTRL_RST    8'hB1
`define RXSO_DIV_RST     8'h03

// Event bits of status and mask.
`define RXSO_EV_W        3
`define RXSO_EV_OVF      0
`define RXSO_EV_BAD      1
`define RXSO_EV_END      2
`define RXSO_EV_NONE     3'h0
`define RXSO_DROP_ONE    16'h0001

`endif

/* File: src/rxso_pkg.sv */
/*
  Types shared by the receive segmented packet output files.
  Assumes rxso_map.svh is on the include path.
*/
`include "rxso_map.svh"

package rxso_pkg;
  typedef logic [`RXSO_DW-1:0] rxso_data_t;
  typedef logic [`RXSO_CW-1:0] rxso_chan_t;
  typedef logic [`RXSO_MW-1:0] rxso_mty_t;
  typedef logic [2:0]          rxso_cnt_t;
  typedef logic [`RXSO_EV_W-1:0] rxso_ev_t;
endpackage : rxso_pkg

/* File: src/rxso_sync.sv */
/*
  Three-stage synchroniser for inputs from outside the clock domain.
  Assumes the caller reads q2 and q3 and treats a change as real only
  when both agree; the first stage feeds nothing but the second.
*/
`timescale 1ns/10ps
`default_nettype none

module rxso_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw input and synchronised stages.
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q2_o,
  output var  logic [W-1:0] q3_o
);

  logic [W-1:0] s1;

  // Plain shift chain; the third stage lets the user filter glitches.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1   <= '0;
      q2_o <= '0;
      q3_o <= '0;
    end else begin
      s1   <= d_i;
      q2_o <= s1;
      q3_o <= q2_o;
    end
  end

endmodule : rxso_sync

`default_nettype wire

/* File: src/rxso_rst_sync.sv */
/*
  Reset synchroniser: asserts at once, releases on the clock.
  Assumes the raw reset is asynchronous and active high.
*/
`timescale 1ns/10ps
`default_nettype none

module rxso_rst_sync (
  // Clock and raw reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Reset for the local domain.
  output var  logic rst_o
);

  logic hold;

  // Release passes two flops so no flop sees a release near its edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold  <= 1'b1;
      rst_o <= 1'b1;
    end else begin
      hold  <= 1'b0;
      rst_o <= hold;
    end
  end

endmodule : rxso_rst_sync

`default_nettype wire

/* File: src/rxso_top.sv */
/*
  Receive segmented packet output: samples the received segment stream
  from the link, packs up to four segments per user bus cycle, reports
  overflow, and holds a small register file with interrupt logic.
  Assumes the link changes its signals away from the rising link clock
  edge and that the link clock is far slower than mclk_i.
*/
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rxso_map.svh"

//////////////////////////////////////////////////////////////////////////
module rxso_top import rxso_pkg::*; (
  // Clock and reset.
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // Received segment stream from the link.
  input  wire logic                      link_clk_i,
  input  wire logic                      link_valid_i,
  input  wire logic                      link_first_i,
  input  wire logic                      link_last_i,
  input  wire logic                      link_bad_i,
  input  wire logic [`RXSO_MW-1:0]       link_empty_i,
  input  wire logic [`RXSO_CW-1:0]       link_chan_i,
  input  wire logic [`RXSO_DW-1:0]       link_data_i,
  // Register port.
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output var  logic [31:0]               reg_rdata_o,
  // Segmented user bus.
  output var  logic [3:0]                receive_segment_valid_o,
  output var  logic [3:0]                receive_segment_first_o,
  output var  logic [3:0]                receive_segment_last_o,
  output var  logic [3:0]                receive_segment_bad_packet_o,
  output var  logic [3:0][`RXSO_MW-1:0]  receive_segment_empty_bytes_o,
  output var  logic [3:0][`RXSO_CW-1:0]  receive_segment_channel_o,
  output var  logic [3:0][`RXSO_DW-1:0]  receive_segment_payload_o,
  // Status outputs.
  output var  logic                      receive_overflow_flag_o,
  output var  logic                      irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Reset and input synchronisation.

  logic                 rst_s;
  logic                 lclk_q2;
  logic                 lclk_q3;
  logic [`RXSO_RAW_W-1:0] link_raw;
  logic [`RXSO_RAW_W-1:0] link_q3;

  // Every flop below except those of u_rst resets from the synchronised reset.
  rxso_rst_sync u_rst (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .rst_o (rst_s)
  );

  // Clock and data pass the same depth, so they stay aligned.
  assign link_raw = {link_valid_i, link_first_i, link_last_i, link_bad_i,
                     link_empty_i, link_chan_i, link_data_i};

  rxso_sync #(.W(1)) u_lclk (
    .clk_i (mclk_i),
    .rst_i (rst_s),
    .d_i   (link_clk_i),
    .q2_o  (lclk_q2),
    .q3_o  (lclk_q3)
  );

  rxso_sync #(.W(`RXSO_RAW_W)) u_ldat (
    .clk_i (mclk_i),
    .rst_i (rst_s),
    .d_i   (link_raw),
    .q2_o  (),
    .q3_o  (link_q3)
  );

  //////////////////////////////////////////////////////////////////////////
  // Link clock edge finder.

  logic lclk_lvl;
  logic next_lclk_lvl;
  logic link_rise;

  // A change counts only when stages two and three agree.
  always_comb begin
    next_lclk_lvl = lclk_lvl;
    if (lclk_q2 == lclk_q3) begin
      next_lclk_lvl = lclk_q3;
    end
  end

  assign link_rise = lclk_q2 & lclk_q3 & ~lclk_lvl;

  always_ff @(posedge mclk_i or posedge rst_s) begin
    if (rst_s) begin
      lclk_lvl <= 1'b0;
    end else begin
      lclk_lvl <= next_lclk_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0]  ctrl;
  logic [7:0]  div;
  rxso_ev_t    status;
  rxso_ev_t    mask;
  logic [15:0] drop;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_div;
  rxso_ev_t    next_status;
  rxso_ev_t    next_mask;
  logic [15:0] next_drop;
  logic [31:0] next_rdata;
  logic        next_irq;
  rxso_ev_t    ev;

  // Writes and reads; a hardware event beats a clear in the same cycle.
  always_comb begin
    next_ctrl   = ctrl;
    next_div    = div;
    next_mask   = mask;
    next_status = status;
    next_rdata  = 32'h0000_0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `RXSO_OFS_CTRL:   next_ctrl = reg_wdata_i[7:0];
        `RXSO_OFS_DIV:    next_div = reg_wdata_i[7:0];
        `RXSO_OFS_STATUS: next_status = status & ~reg_wdata_i[2:0];
        `RXSO_OFS_MASK:   next_mask = reg_wdata_i[2:0];
        default:          next_ctrl = ctrl;
      endcase
    end
    next_status = next_status | ev;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `RXSO_OFS_CTRL:   next_rdata = {24'h00_0000, ctrl};
        `RXSO_OFS_DIV:    next_rdata = {24'h00_0000, div};
        `RXSO_OFS_STATUS: next_rdata = {29'h0000_0000, status};
        `RXSO_OFS_MASK:   next_rdata = {29'h0000_0000, mask};
        `RXSO_OFS_DROP:   next_rdata = {16'h0000, drop};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge mclk_i or posedge rst_s) begin
    if (rst_s) begin
      ctrl        <= `RXSO_CTRL_RST;
      div         <= `RXSO_DIV_RST;
      status      <= `RXSO_EV_NONE;
      mask        <= `RXSO_EV_NONE;
      reg_rdata_o <= 32'h0000_0000;
      irq_o       <= 1'b0;
      receive_overflow_flag_o <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      div         <= next_div;
      status      <= next_status;
      mask        <= next_mask;
      reg_rdata_o <= next_rdata;
      irq_o       <= next_irq;
      receive_overflow_flag_o <= next_status[`RXSO_EV_OVF];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // User bus cycle divider.

  logic [7:0] tcnt;
  logic [7:0] next_tcnt;
  logic       tick;

  // One user bus cycle every div+1 clocks; slower buses risk overflow.
  assign tick = (tcnt == div);

  always_comb begin
    next_tcnt = tick ? 8'h00 : 8'(tcnt + 8'h01);
  end

  always_ff @(posedge mclk_i or posedge rst_s) begin
    if (rst_s) begin
      tcnt <= 8'h00;
    end else begin
      tcnt <= next_tcnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Segment packing and output.

  logic [3:0]               slot_first;
  logic [3:0]               slot_last;
  logic [3:0]               slot_bad;
  logic [3:0][`RXSO_MW-1:0] slot_mty;
  logic [3:0][`RXSO_CW-1:0] slot_chan;
  logic [3:0][`RXSO_DW-1:0] slot_data;
  rxso_cnt_t                cnt;
  logic [3:0]               next_slot_first;
  logic [3:0]               next_slot_last;
  logic [3:0]               next_slot_bad;
  logic [3:0][`RXSO_MW-1:0] next_slot_mty;
  logic [3:0][`RXSO_CW-1:0] next_slot_chan;
  logic [3:0][`RXSO_DW-1:0] next_slot_data;
  rxso_cnt_t                next_cnt;
  logic [3:0]               next_vld;
  logic [3:0]               next_fst;
  logic [3:0]               next_lst;
  logic [3:0]               next_bad;
  logic [3:0][`RXSO_MW-1:0] next_mty;
  logic [3:0][`RXSO_CW-1:0] next_chn;
  logic [3:0][`RXSO_DW-1:0] next_pay;
  logic [15:0]              drop_inc;
  logic [3:0]               rng;
  rxso_chan_t               chan_lim;
  rxso_cnt_t                idx;
  logic                     emit;

  // Range field gives the channel width; values above 11 mean 11 bits.
  assign rng = (ctrl[`RXSO_CTRL_RNG_HI:`RXSO_CTRL_RNG_LO] > `RXSO_CHAN_BITS)
             ? `RXSO_CHAN_BITS : ctrl[`RXSO_CTRL_RNG_HI:`RXSO_CTRL_RNG_LO];
  assign chan_lim = `RXSO_CHAN_ALL >> (`RXSO_CHAN_BITS - rng);
  assign emit = tick && (cnt != `RXSO_CNT_ZERO);
  assign idx  = emit ? `RXSO_CNT_ZERO : cnt;

  // Slots fill in arrival order, so slot 0 always holds the oldest segment of a bus cycle.
  always_comb begin
    next_slot_first = slot_first;
    next_slot_last  = slot_last;
    next_slot_bad   = slot_bad;
    next_slot_mty   = slot_mty;
    next_slot_chan  = slot_chan;
    next_slot_data  = slot_data;
    next_cnt        = idx;
    next_vld        = 4'h0;
    next_fst        = 4'h0;
    next_lst        = 4'h0;
    next_bad        = 4'h0;
    next_mty        = '0;
    next_chn        = '0;
    next_pay        = '0;
    ev              = `RXSO_EV_NONE;
    drop_inc        = 16'h0000;
    for (int i = 0; i < `RXSO_SEGS; i++) begin
      if (emit && (3'(i) < cnt)) begin
        next_vld[i] = 1'b1;
        next_pay[i] = slot_data[i];
        next_chn[i] = slot_chan[i];
        next_fst[i] = slot_first[i];
        next_lst[i] = slot_last[i];
        next_bad[i] = slot_last[i] & slot_bad[i];
        next_mty[i] = (slot_last[i] && !slot_bad[i])
                    ? slot_mty[i] : `RXSO_MTY_NONE;
        ev[`RXSO_EV_BAD] = ev[`RXSO_EV_BAD] | next_bad[i];
        ev[`RXSO_EV_END] = ev[`RXSO_EV_END] | slot_last[i];
      end
    end
    if (link_rise && link_q3[`RXSO_RAW_W-1] && ctrl[`RXSO_CTRL_EN]) begin
      if (idx == `RXSO_CNT_FULL) begin
        ev[`RXSO_EV_OVF] = 1'b1;
        drop_inc = `RXSO_DROP_ONE;
      end else begin
        next_slot_first[idx[1:0]] = link_q3[`RXSO_RAW_W-2];
        next_slot_last[idx[1:0]]  = link_q3[`RXSO_RAW_W-3];
        next_slot_bad[idx[1:0]]   = link_q3[`RXSO_RAW_W-4];
        next_slot_mty[idx[1:0]]   =
          link_q3[`RXSO_DW+`RXSO_CW +: `RXSO_MW];
        next_slot_chan[idx[1:0]]  =
          link_q3[`RXSO_DW +: `RXSO_CW] & chan_lim;
        next_slot_data[idx[1:0]]  = link_q3[`RXSO_DW-1:0];
        next_cnt = 3'(idx + `RXSO_CNT_ONE);
      end
    end
    next_drop = 16'(drop + drop_inc);
  end

  always_ff @(posedge mclk_i or posedge rst_s) begin
    if (rst_s) begin
      slot_first <= 4'h0;
      slot_last  <= 4'h0;
      slot_bad   <= 4'h0;
      slot_mty   <= '0;
      slot_chan  <= '0;
      slot_data  <= '0;
      cnt        <= `RXSO_CNT_ZERO;
      drop       <= 16'h0000;
      receive_segment_valid_o       <= 4'h0;
      receive_segment_first_o       <= 4'h0;
      receive_segment_last_o        <= 4'h0;
      receive_segment_bad_packet_o  <= 4'h0;
      receive_segment_empty_bytes_o <= '0;
      receive_segment_channel_o     <= '0;
      receive_segment_payload_o     <= '0;
    end else begin
      slot_first <= next_slot_first;
      slot_last  <= next_slot_last;
      slot_bad   <= next_slot_bad;
      slot_mty   <= next_slot_mty;
      slot_chan  <= next_slot_chan;
      slot_data  <= next_slot_data;
      cnt        <= next_cnt;
      drop       <= next_drop;
      receive_segment_valid_o       <= next_vld;
      receive_segment_first_o       <= next_fst;
      receive_segment_last_o        <= next_lst;
      receive_segment_bad_packet_o  <= next_bad;
      receive_segment_empty_bytes_o <= next_mty;
      receive_segment_channel_o     <= next_chn;
      receive_segment_payload_o     <= next_pay;
    end
  end

endmodule : rxso_top

`default_nettype wire

/* File: dv/rxso_top_properties.sv */
/*
  Checker for the receive segmented packet output: port-level relations.
  Assumes it is bound to rxso_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rxso_map.svh"

module rxso_top_check (
  // Clock, reset and register port.
  input wire logic                     mclk_i,
  input wire logic                     rst_i,
  input wire logic [7:0]               reg_addr_i,
  input wire logic [31:0]              reg_wdata_i,
  input wire logic                     reg_wr_i,
  // Segmented user bus and overflow flag.
  input wire logic [3:0]               receive_segment_valid_o,
  input wire logic [3:0]               receive_segment_first_o,
  input wire logic [3:0]               receive_segment_last_o,
  input wire logic [3:0]               receive_segment_bad_packet_o,
  input wire logic [3:0][`RXSO_MW-1:0] receive_segment_empty_bytes_o,
  input wire logic [3:0][`RXSO_CW-1:0] receive_segment_channel_o,
  input wire logic [3:0][`RXSO_DW-1:0] receive_segment_payload_o,
  input wire logic                     receive_overflow_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Short aliases keep the properties readable.
  wire logic [3:0] v   = receive_segment_valid_o;
  wire logic [3:0] l   = receive_segment_last_o;
  wire logic [3:0] b   = receive_segment_bad_packet_o;
  wire logic       ovf = receive_overflow_flag_o;
  logic      [3:0] mty_bad;
  logic      [3:0] chan_bad;
  logic      [3:0] pay_bad;

  ////////////////////////////////////////////////////////////////////////
  // Per-slot qualifier checks; stale fields would mislead user logic.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mty_bad[i]  = (receive_segment_empty_bytes_o[i] != 4'h0) &&
                    !(v[i] && l[i] && !b[i]);
      chan_bad[i] = !v[i] && (receive_segment_channel_o[i] != '0);
      pay_bad[i]  = !v[i] && (receive_segment_payload_o[i] != '0);
    end
  end

  a_valid_contig:
    assert property (v inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("valid slots not contiguous from slot 0");
  a_first_qual:
    assert property ((receive_segment_first_o & ~v) == 4'h0)
      else $error("first flag on idle slot");
  a_last_qual:
    assert property ((l & ~v) == 4'h0)
      else $error("last flag on idle slot");
  a_bad_needs_last:
    assert property ((b & ~(v & l)) == 4'h0)
      else $error("bad flag without valid last");
  a_empty_on_last:
    assert property (mty_bad == 4'h0)
      else $error("empty count outside a good last slot");
  a_chan_qual:
    assert property (chan_bad == 4'h0)
      else $error("channel on idle slot");
  a_payload_qual:
    assert property (pay_bad == 4'h0)
      else $error("payload on idle slot");
  a_ovf_sticky:
    assert property ($fell(ovf) |-> $past(reg_wr_i) && $past(reg_wdata_i[0])
                     && ($past(reg_addr_i) == `RXSO_OFS_STATUS))
      else $error("overflow flag cleared without a status write");

  // Main scenarios worth seeing.
  c_full_bus: cover property (v == 4'hF);
  c_ovf_rise: cover property ($rose(ovf));
  c_bad_seen: cover property ((b & v) != 4'h0);
endmodule : rxso_top_check

bind rxso_top rxso_top_check rxso_top_check_inst (.*);

`default_nettype wire

/* File: dv/rxso_link_model.sv */
/*
  Link source model: one segment per link clock period, 160 ns.
  Assumes the bench calls send for a burst and idle after it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rxso_map.svh"

module rxso_link_model (
  // Link clock, valid and packed {first,last,bad,empty,chan,data}.
  output var logic                clk_o,
  output var logic                valid_o,
  output var logic [`RXSO_LW-1:0] seg_o
);
  ////////////////////////////////////////////////////////////////////////
  // Clock stands still between frames.
  initial begin
    clk_o   = 1'b0;
    valid_o = 1'b0;
    seg_o   = '0;
  end

  // Fields settle 40 ns before the rising edge and hold 120 ns after.
  task automatic send(input logic [`RXSO_LW-1:0] s);
    valid_o = 1'b1;
    seg_o   = s;
    #40 clk_o = 1'b1;
    #80 clk_o = 1'b0;
    #40;
  endtask : send

  // Released fields show a changed pattern, never the last segment.
  task automatic idle();
    valid_o = 1'b0;
    seg_o   = ~seg_o;
  endtask : idle
endmodule : rxso_link_model

`default_nettype wire

/* File: dv/testbench.sv */
/*
  Self-checking bench for rxso_top: register port, segment stream,
  interrupt and overflow. Assumes the link model and checker files.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rxso_map.svh"

module testbench import rxso_pkg::*;;
  logic                      mclk  = 1'b0;
  logic                      rst   = 1'b1;
  logic [7:0]                addr  = 8'h00;
  logic [31:0]               wdata = 32'h0;
  logic                      wr    = 1'b0;
  logic                      rd    = 1'b0;
  logic [31:0]               rdata;
  logic [3:0]                val, fst, lst, bad;
  logic [3:0][`RXSO_MW-1:0]  mty;
  logic [3:0][`RXSO_CW-1:0]  chan;
  logic [3:0][`RXSO_DW-1:0]  pay;
  logic                      ovf, irq, lclk, lval;
  logic [`RXSO_LW-1:0]       lseg;
  logic [`RXSO_LW-1:0]       got_q[$];
  logic [`RXSO_LW-1:0]       exp_q[$];
  rxso_chan_t                rmask = 11'h7FF;
  logic [31:0]               rv;
  int                        n_fail = 0;
  int                        n_tests = 0;
  int                        cyc = 0;

  rxso_link_model lnk (.clk_o(lclk), .valid_o(lval), .seg_o(lseg));
  rxso_top rxso_top_inst (
    .mclk_i(mclk), .rst_i(rst), .link_clk_i(lclk), .link_valid_i(lval),
    .link_first_i(lseg[145]), .link_last_i(lseg[144]),
    .link_bad_i(lseg[143]), .link_empty_i(lseg[142:139]),
    .link_chan_i(lseg[138:128]), .link_data_i(lseg[127:0]),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .receive_segment_valid_o(val),
    .receive_segment_first_o(fst), .receive_segment_last_o(lst),
    .receive_segment_bad_packet_o(bad),
    .receive_segment_empty_bytes_o(mty), .receive_segment_channel_o(chan),
    .receive_segment_payload_o(pay), .receive_overflow_flag_o(ovf),
    .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////
  // Clock, cycle ceiling against hangs, and slot-ordered bus capture.
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
    for (int i = 0; i < 4; i++) begin
      if (val[i] === 1'b1) begin
        got_q.push_back({fst[i], lst[i], bad[i], mty[i], chan[i], pay[i]});
      end
    end
  end

  task automatic chk(input string nm, input logic [`RXSO_LW-1:0] seen,
                     input logic [`RXSO_LW-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
    chk("register", rv, exp);
  endtask : rd_reg

  // Expected bus view: bad only with last, empty only on a good last.
  task automatic seg(input logic f, l, b, input rxso_mty_t m,
                     input rxso_chan_t c);
    rxso_data_t d;
    d = {16{c[3:0], m}};
    exp_q.push_back({f, l, b & l, (l & ~b) ? m : 4'h0,
                     c & rmask, d});
    lnk.send({f, l, b, m, c, d});
  endtask : seg

  // The wait covers a full slow bus period of 256 clocks.
  task automatic drain();
    lnk.idle();
    for (int t = 0; t < 600 && got_q.size() < exp_q.size(); t++) begin
      @(posedge mclk);
    end
    while (exp_q.size() > 0) begin
      chk("segment", (got_q.size() > 0) ? got_q.pop_front() : '1,
          exp_q.pop_front());
    end
    chk("extra segments", got_q.size(), 0);
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    rd_reg(`RXSO_OFS_CTRL, 32'hB1);
    rd_reg(`RXSO_OFS_DIV, 32'h3);
    rd_reg(`RXSO_OFS_MASK, 32'h0);
    wr_reg(`RXSO_OFS_DROP, 32'h55);
    rd_reg(`RXSO_OFS_DROP, 32'h0);
    rd_reg(8'h14, 32'h0);
  endtask : t_regs

  task automatic t_packet();
    wr_reg(`RXSO_OFS_MASK, 32'h4);
    seg(1'b1, 1'b0, 1'b0, 4'h3, 11'h005);
    seg(1'b0, 1'b0, 1'b0, 4'h0, 11'h005);
    seg(1'b0, 1'b1, 1'b0, 4'h9, 11'h005);
    drain();
    rd_reg(`RXSO_OFS_STATUS, 32'h4);
    chk("irq", irq, 1'b1);
    wr_reg(`RXSO_OFS_STATUS, 32'h4);
    chk("irq", irq, 1'b0);
  endtask : t_packet

  task automatic t_bad();
    seg(1'b1, 1'b1, 1'b1, 4'h5, 11'h007);
    drain();
    rd_reg(`RXSO_OFS_STATUS, 32'h6);
    wr_reg(`RXSO_OFS_STATUS, 32'h7);
  endtask : t_bad

  task automatic t_range();
    wr_reg(`RXSO_OFS_CTRL, 32'h41);
    rmask = 11'h00F;
    seg(1'b1, 1'b1, 1'b0, 4'h0, 11'h5A3);
    drain();
    wr_reg(`RXSO_OFS_CTRL, 32'h01);
    rmask = 11'h000;
    seg(1'b1, 1'b1, 1'b0, 4'h2, 11'h7FF);
    drain();
    // With the enable off a segment must vanish without a trace.
    wr_reg(`RXSO_OFS_CTRL, 32'h00);
    lnk.send({3'h4, 4'h0, 11'h001, 128'h0});
    repeat (8) @(posedge mclk);
    drain();
    wr_reg(`RXSO_OFS_CTRL, 32'hB1);
    rmask = 11'h7FF;
  endtask : t_range

  // Slow bus: one segment finds the tick phase, then six segments land
  // before the next tick, so four fill the bus and two are lost.
  task automatic t_ovf();
    wr_reg(`RXSO_OFS_MASK, 32'h1);
    wr_reg(`RXSO_OFS_DIV, 32'hFF);
    seg(1'b1, 1'b1, 1'b0, 4'h0, 11'h001);
    drain();
    chk("irq", irq, 1'b0);
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        seg(i == 0, i == 3, 1'b0, 4'(i), 11'(i));
      end else begin
        lnk.send('1);
      end
    end
    drain();
    chk("overflow", ovf, 1'b1);
    chk("irq", irq, 1'b1);
    rd_reg(`RXSO_OFS_DROP, 32'h2);
    chk("drops", rv != 32'h0, 1'b1);
    wr_reg(`RXSO_OFS_STATUS, 32'h1);
    chk("overflow", ovf, 1'b0);
    chk("irq", irq, 1'b0);
    wr_reg(`RXSO_OFS_DIV, 32'h3);
  endtask : t_ovf

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Reset held for 16 clocks while the link clock stands still, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    t_regs();
    t_packet();
    t_bad();
    t_range();
    t_ovf();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
